// File: rtl/dcbi_pkg.sv
// Constants and types shared by the data cache block invalidate logic.
// Assumes a 32-bit physical address space and a direct-mapped data cache.
package dcbi_pkg;

  localparam int ADDR_W      = 32;
  localparam int DATA_W      = 32;
  localparam int AXI_ADDR_W  = 8;
  localparam int BLOCK_OFF_W = 5;
  localparam int INDEX_W     = 4;
  localparam int NUM_LINES   = 16;
  localparam int TAG_W       = ADDR_W - BLOCK_OFF_W - INDEX_W;
  localparam int RES_W       = 3;
  localparam int CNT_W       = 16;

  // Register byte offsets
  localparam logic [AXI_ADDR_W-1:0] REG_CTRL        = 8'h00;
  localparam logic [AXI_ADDR_W-1:0] REG_STATUS      = 8'h04;
  localparam logic [AXI_ADDR_W-1:0] REG_INV_CNT     = 8'h08;
  localparam logic [AXI_ADDR_W-1:0] REG_DISCARD_CNT = 8'h0c;
  localparam logic [AXI_ADDR_W-1:0] REG_BCAST_CNT   = 8'h10;
  localparam logic [AXI_ADDR_W-1:0] REG_FAULT_CNT   = 8'h14;

  // Field positions and reset values
  localparam int          CTRL_SNOOP_EN_BIT = 0;
  localparam logic        CTRL_SNOOP_EN_RST = 1'b1;
  localparam int          STAT_BUSY_BIT     = 0;
  localparam int          STAT_RES_LSB      = 4;
  localparam logic [1:0]  RESP_OKAY         = 2'b00;
  localparam logic [1:0]  RESP_SLVERR       = 2'b10;

  typedef enum logic [RES_W-1:0] {
    RES_NONE         = 3'b000,
    RES_LOCAL        = 3'b001,
    RES_BCAST        = 3'b010,
    RES_MISS         = 3'b011,
    RES_DIRECT_STORE = 3'b100,
    RES_PRIV_FAULT   = 3'b101,
    RES_XLATE_FAULT  = 3'b110
  } dcbi_result_e;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_XLATE  = 2'b01,
    ST_LOOKUP = 2'b10,
    ST_BCAST  = 2'b11
  } dcbi_state_e;

endpackage : dcbi_pkg

// File: rtl/dcbi_line.sv
// One data cache line: valid, modified and tag state.
// Assumes a synchronised active-low reset; invalidate beats fill in one cycle.
`timescale 1ns/1ps
module dcbi_line (
  input  wire logic                      clk_sys,
  input  wire logic                      rst_n,
  input  wire logic                      fill_en,
  input  wire logic [dcbi_pkg::TAG_W-1:0] fill_tag,
  input  wire logic                      fill_dirty,
  input  wire logic                      inv_en,
  output logic                           valid,
  output logic                           dirty,
  output logic [dcbi_pkg::TAG_W-1:0]     tag
);
  import dcbi_pkg::*;

  logic             valid_q;
  logic             dirty_q;
  logic [TAG_W-1:0] tag_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      valid_q <= 1'b0;
    end else if (inv_en) begin
      valid_q <= 1'b0;
    end else if (fill_en) begin
      valid_q <= 1'b1;
    end
  end

  // Modified data is dropped, never written back
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dirty_q <= 1'b0;
    end else if (inv_en) begin
      dirty_q <= 1'b0;
    end else if (fill_en) begin
      dirty_q <= fill_dirty;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tag_q <= '0;
    end else if (fill_en && !inv_en) begin
      tag_q <= fill_tag;
    end
  end

  assign valid = valid_q;
  assign dirty = dirty_q;
  assign tag   = tag_q;

endmodule : dcbi_line

// File: rtl/dcbi_top.sv
// Data cache block invalidate engine with its cache state and AXI4-Lite registers.
// Assumes pipeline, translation unit, fill path and shared bus all run on clk_sys.
`timescale 1ns/1ps
module dcbi_top (
  input  wire logic                            clk_sys,
  input  wire logic                            nrst,
  input  wire logic                            req_valid,
  output logic                                 req_ready,
  input  wire logic [dcbi_pkg::ADDR_W-1:0]     req_ea,
  input  wire logic                            req_supervisor,
  input  wire logic                            segment_direct_store_flag,
  output logic                                 done,
  output logic [dcbi_pkg::RES_W-1:0]           done_result,
  output logic                                 xlat_req,
  output logic [dcbi_pkg::ADDR_W-1:0]          xlat_ea,
  output logic                                 xlat_is_store,
  input  wire logic                            xlat_done,
  input  wire logic                            xlat_fault,
  input  wire logic [dcbi_pkg::ADDR_W-1:0]     xlat_pa,
  input  wire logic                            xlat_coherent,
  input  wire logic                            fill_valid,
  input  wire logic [dcbi_pkg::ADDR_W-1:0]     fill_pa,
  input  wire logic                            fill_dirty,
  output logic                                 bcast_valid,
  output logic [dcbi_pkg::ADDR_W-1:0]          bcast_pa,
  input  wire logic                            bcast_ack,
  input  wire logic                            snoop_valid,
  input  wire logic [dcbi_pkg::ADDR_W-1:0]     snoop_pa,
  input  wire logic [dcbi_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                            s_axi_awvalid,
  output logic                                 s_axi_awready,
  input  wire logic [dcbi_pkg::DATA_W-1:0]     s_axi_wdata,
  input  wire logic [3:0]                      s_axi_wstrb,
  input  wire logic                            s_axi_wvalid,
  output logic                                 s_axi_wready,
  output logic [1:0]                           s_axi_bresp,
  output logic                                 s_axi_bvalid,
  input  wire logic                            s_axi_bready,
  input  wire logic [dcbi_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                            s_axi_arvalid,
  output logic                                 s_axi_arready,
  output logic [dcbi_pkg::DATA_W-1:0]          s_axi_rdata,
  output logic [1:0]                           s_axi_rresp,
  output logic                                 s_axi_rvalid,
  input  wire logic                            s_axi_rready
);
  import dcbi_pkg::*;

  logic                  rst_meta_q;
  logic                  rst_n;
  dcbi_state_e           state_q;
  logic [ADDR_W-1:0]     pa_q;
  logic                  coherent_q;
  logic                  snoop_en_q;
  logic [RES_W-1:0]      last_res_q;
  logic [CNT_W-1:0]      inv_cnt_q;
  logic [CNT_W-1:0]      discard_cnt_q;
  logic [CNT_W-1:0]      bcast_cnt_q;
  logic [CNT_W-1:0]      fault_cnt_q;
  logic                  aw_held_q;
  logic                  w_held_q;
  logic [AXI_ADDR_W-1:0] awaddr_q;
  logic [DATA_W-1:0]     wdata_q;
  logic [3:0]            wstrb_q;
  logic [NUM_LINES-1:0]  line_valid;
  logic [NUM_LINES-1:0]  line_dirty;
  logic [TAG_W-1:0]      line_tag [NUM_LINES];
  logic [NUM_LINES-1:0]  line_inv;
  logic [NUM_LINES-1:0]  line_fill;

  // Reset release through two flops
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // Block index and tag ignore the byte offset inside the block
  wire [INDEX_W-1:0] lk_idx    = pa_q[BLOCK_OFF_W +: INDEX_W];
  wire [TAG_W-1:0]   lk_tag    = pa_q[ADDR_W-1 -: TAG_W];
  wire [INDEX_W-1:0] snoop_idx = snoop_pa[BLOCK_OFF_W +: INDEX_W];
  wire [TAG_W-1:0]   snoop_tag = snoop_pa[ADDR_W-1 -: TAG_W];
  wire [INDEX_W-1:0] fill_idx  = fill_pa[BLOCK_OFF_W +: INDEX_W];

  wire lk_hit    = line_valid[lk_idx] && (line_tag[lk_idx] == lk_tag);
  wire local_inv = (state_q == ST_LOOKUP) && lk_hit;
  wire snoop_hit = snoop_valid && snoop_en_q && line_valid[snoop_idx]
                   && (line_tag[snoop_idx] == snoop_tag);
  wire accept    = (state_q == ST_IDLE) && req_valid && req_ready;
  wire priv_fail = accept && !req_supervisor;
  wire ds_noop   = accept && req_supervisor && segment_direct_store_flag;
  wire xl_fail   = (state_q == ST_XLATE) && xlat_done && xlat_fault;
  wire bcast_hs  = bcast_valid && bcast_ack;
  wire discards  = (local_inv && line_dirty[lk_idx])
                   || (snoop_hit && line_dirty[snoop_idx]);

  genvar gi;
  generate
    for (gi = 0; gi < NUM_LINES; gi++) begin : g_line
      assign line_inv[gi]  = (local_inv && (lk_idx == INDEX_W'(gi)))
                             || (snoop_hit && (snoop_idx == INDEX_W'(gi)));
      assign line_fill[gi] = fill_valid && (fill_idx == INDEX_W'(gi));
      dcbi_line u_line (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .fill_en    (line_fill[gi]),
        .fill_tag   (fill_pa[ADDR_W-1 -: TAG_W]),
        .fill_dirty (fill_dirty),
        .inv_en     (line_inv[gi]),
        .valid      (line_valid[gi]),
        .dirty      (line_dirty[gi]),
        .tag        (line_tag[gi])
      );
    end
  endgenerate

  // Invalidate sequencer; cache attributes other than coherency play no part
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (accept && req_supervisor && !segment_direct_store_flag) begin
            state_q <= ST_XLATE;
          end
        end
        ST_XLATE: begin
          if (xlat_done) begin
            state_q <= xlat_fault ? ST_IDLE : ST_LOOKUP;
          end
        end
        ST_LOOKUP: begin
          state_q <= coherent_q ? ST_BCAST : ST_IDLE;
        end
        ST_BCAST: begin
          if (bcast_ack) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      req_ready <= 1'b0;
    end else if (accept) begin
      req_ready <= 1'b0;
    end else if (done) begin
      req_ready <= 1'b1;
    end else if (state_q == ST_IDLE) begin
      req_ready <= 1'b1;
    end
  end

  // Translation request travels as a store; no history-bit update is asked for
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      xlat_req      <= 1'b0;
      xlat_ea       <= '0;
      xlat_is_store <= 1'b1;
    end else begin
      xlat_is_store <= 1'b1;
      if (accept && req_supervisor && !segment_direct_store_flag) begin
        xlat_req <= 1'b1;
        xlat_ea  <= req_ea;
      end else if (xlat_done) begin
        xlat_req <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pa_q       <= '0;
      coherent_q <= 1'b0;
    end else if ((state_q == ST_XLATE) && xlat_done && !xlat_fault) begin
      pa_q       <= xlat_pa;
      coherent_q <= xlat_coherent;
    end
  end

  // Coherent targets go to the bus whether or not the local copy hit
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bcast_valid <= 1'b0;
      bcast_pa    <= '0;
    end else if ((state_q == ST_LOOKUP) && coherent_q) begin
      bcast_valid <= 1'b1;
      bcast_pa    <= {pa_q[ADDR_W-1:BLOCK_OFF_W], {BLOCK_OFF_W{1'b0}}};
    end else if (bcast_hs) begin
      bcast_valid <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      done        <= 1'b0;
      done_result <= RES_NONE;
    end else begin
      done <= priv_fail || ds_noop || xl_fail || bcast_hs
              || ((state_q == ST_LOOKUP) && !coherent_q);
      if (priv_fail) begin
        done_result <= RES_PRIV_FAULT;
      end else if (ds_noop) begin
        done_result <= RES_DIRECT_STORE;
      end else if (xl_fail) begin
        done_result <= RES_XLATE_FAULT;
      end else if (bcast_hs) begin
        done_result <= RES_BCAST;
      end else if ((state_q == ST_LOOKUP) && !coherent_q) begin
        done_result <= lk_hit ? RES_LOCAL : RES_MISS;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      last_res_q <= RES_NONE;
    end else if (done) begin
      last_res_q <= done_result;
    end
  end

  // Register writes: address and data taken in either order
  wire wr_go = aw_held_q && w_held_q && !s_axi_bvalid;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_q     <= 1'b0;
      awaddr_q      <= '0;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready) && !wr_go;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      w_held_q     <= 1'b0;
      wdata_q      <= '0;
      wstrb_q      <= '0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_held_q && !(s_axi_wvalid && s_axi_wready) && !wr_go;
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held_q <= 1'b0;
      end
    end
  end

  wire wr_mapped = (awaddr_q == REG_CTRL) || (awaddr_q == REG_STATUS)
                   || (awaddr_q == REG_INV_CNT) || (awaddr_q == REG_DISCARD_CNT)
                   || (awaddr_q == REG_BCAST_CNT) || (awaddr_q == REG_FAULT_CNT);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      snoop_en_q <= CTRL_SNOOP_EN_RST;
    end else if (wr_go && (awaddr_q == REG_CTRL) && wstrb_q[0]) begin
      snoop_en_q <= wdata_q[CTRL_SNOOP_EN_BIT];
    end
  end

  // Counters clear on a write to their own offset; an event in the clearing cycle counts as one
  function automatic logic [CNT_W-1:0] cnt_next(input logic [CNT_W-1:0] cur,
                                                input logic clr, input logic inc);
    logic [CNT_W-1:0] base;
    base = clr ? '0 : cur;
    return inc ? base + 1'b1 : base;
  endfunction : cnt_next

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      inv_cnt_q     <= '0;
      discard_cnt_q <= '0;
      bcast_cnt_q   <= '0;
      fault_cnt_q   <= '0;
    end else begin
      inv_cnt_q     <= cnt_next(inv_cnt_q, wr_go && (awaddr_q == REG_INV_CNT),
                                local_inv || snoop_hit);
      discard_cnt_q <= cnt_next(discard_cnt_q, wr_go && (awaddr_q == REG_DISCARD_CNT),
                                discards);
      bcast_cnt_q   <= cnt_next(bcast_cnt_q, wr_go && (awaddr_q == REG_BCAST_CNT),
                                bcast_hs);
      fault_cnt_q   <= cnt_next(fault_cnt_q, wr_go && (awaddr_q == REG_FAULT_CNT),
                                priv_fail || xl_fail);
    end
  end

  // Register reads
  logic [DATA_W-1:0] rd_word;
  logic              rd_ok;

  always_comb begin
    rd_word = '0;
    rd_ok   = 1'b1;
    case (s_axi_araddr)
      REG_CTRL: begin
        rd_word[CTRL_SNOOP_EN_BIT] = snoop_en_q;
      end
      REG_STATUS: begin
        rd_word[STAT_BUSY_BIT]                = (state_q != ST_IDLE);
        rd_word[STAT_RES_LSB +: RES_W]        = last_res_q;
      end
      REG_INV_CNT: begin
        rd_word[CNT_W-1:0] = inv_cnt_q;
      end
      REG_DISCARD_CNT: begin
        rd_word[CNT_W-1:0] = discard_cnt_q;
      end
      REG_BCAST_CNT: begin
        rd_word[CNT_W-1:0] = bcast_cnt_q;
      end
      REG_FAULT_CNT: begin
        rd_word[CNT_W-1:0] = fault_cnt_q;
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : dcbi_top

// File: testbench/dcbi_checker.sv
// Assertions on the invalidate engine's pipeline, translation and broadcast ports.
// Bound into dcbi_top; sees only its ports, one clock domain.
`timescale 1ns/1ps
module dcbi_checker
  import dcbi_pkg::*;
(
  input wire logic                        clk_sys,
  input wire logic                        nrst,
  input wire logic                        req_valid,
  input wire logic                        req_ready,
  input wire logic [dcbi_pkg::ADDR_W-1:0] req_ea,
  input wire logic                        req_supervisor,
  input wire logic                        segment_direct_store_flag,
  input wire logic                        done,
  input wire logic [dcbi_pkg::RES_W-1:0]  done_result,
  input wire logic                        xlat_req,
  input wire logic [dcbi_pkg::ADDR_W-1:0] xlat_ea,
  input wire logic                        xlat_is_store,
  input wire logic                        xlat_done,
  input wire logic                        xlat_fault,
  input wire logic [dcbi_pkg::ADDR_W-1:0] xlat_pa,
  input wire logic                        xlat_coherent,
  input wire logic                        bcast_valid,
  input wire logic [dcbi_pkg::ADDR_W-1:0] bcast_pa,
  input wire logic                        bcast_ack
);
  logic tk;
  logic xd;
  assign tk = req_valid && req_ready;
  assign xd = xlat_req && xlat_done && !xlat_fault;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  AST_PRIV: assert property (tk && !req_supervisor |=> done && !xlat_req
    && done_result == RES_PRIV_FAULT) else $error("user request not refused");
  AST_DS: assert property (tk && req_supervisor && segment_direct_store_flag |=>
    done && !xlat_req && done_result == RES_DIRECT_STORE) else $error("direct-store not no-op");
  AST_XREQ: assert property (tk && req_supervisor && !segment_direct_store_flag |=>
    xlat_req && xlat_is_store && xlat_ea == $past(req_ea)) else $error("bad store translation");
  AST_XFLT: assert property (xlat_req && xlat_done && xlat_fault |=> done
    && done_result == RES_XLATE_FAULT) else $error("translation fault not reported");
  AST_COH: assert property (xd && xlat_coherent |-> ##2 bcast_valid
    && bcast_pa == {$past(xlat_pa[31:5], 2), 5'h00}) else $error("no block broadcast");
  AST_NC: assert property (xd && !xlat_coherent |-> !bcast_valid [*2] ##1 done
    && !bcast_valid && (done_result == RES_LOCAL || done_result == RES_MISS))
    else $error("noncoherent result wrong");
  AST_HOLD: assert property (bcast_valid && !bcast_ack |=> bcast_valid
    && $stable(bcast_pa)) else $error("broadcast dropped early");
  AST_ACK: assert property (bcast_valid && bcast_ack |=> !bcast_valid && done
    && done_result == RES_BCAST) else $error("broadcast not finished");

  cover property (xd && xlat_coherent);
  cover property (tk && segment_direct_store_flag);
  cover property (done && done_result == RES_LOCAL);
endmodule : dcbi_checker

bind dcbi_top dcbi_checker i_chk (.*);

// File: testbench/dcbi_partner.sv
// Far side of the invalidate engine: translation unit and shared invalidate bus.
// Assumes the engine's clock; the bench sets attributes, fault and reply lag.
`timescale 1ns/1ps
module dcbi_partner (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        xlat_req,
  input  wire logic [31:0] xlat_ea,
  input  wire logic        bcast_valid,
  input  wire logic        coh_mode,
  input  wire logic        fault_mode,
  input  wire logic [3:0]  lag,
  output logic             xlat_done,
  output logic             xlat_fault,
  output logic [31:0]      xlat_pa,
  output logic             xlat_coherent,
  output logic             bcast_ack
);
  logic [3:0] cnt_q;
  logic       seen_q;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 4'h0;
      seen_q <= 1'b0;
      xlat_done <= 1'b0;
      bcast_ack <= 1'b0;
      xlat_fault <= 1'b0;
      xlat_coherent <= 1'b0;
      xlat_pa <= 32'h0;
    end else begin
      xlat_done <= 1'b0;
      bcast_ack <= 1'b0;
      // Address and attributes are only meaningful with the done pulse
      xlat_pa <= ~xlat_pa;
      xlat_fault <= ~xlat_fault;
      xlat_coherent <= ~xlat_coherent;
      if (!(xlat_req || bcast_valid)) begin
        seen_q <= 1'b0;
        cnt_q <= 4'h0;
      end else if (!seen_q && cnt_q != lag) begin
        cnt_q <= cnt_q + 4'h1;
      end else if (!seen_q) begin
        seen_q <= 1'b1;
        if (xlat_req) begin
          xlat_done <= 1'b1;
          xlat_pa <= xlat_ea;
          xlat_fault <= fault_mode;
          xlat_coherent <= coh_mode;
        end else begin
          bcast_ack <= 1'b1;
        end
      end
    end
  end
endmodule : dcbi_partner

// File: testbench/test_data_cache_block_invalidate.sv
// Bench for dcbi_top: pipeline requests, fills, snoops and AXI4-Lite registers.
// Assumes dcbi_partner answers translation and broadcast on the far side.
`timescale 1ns/1ps
module test_data_cache_block_invalidate;
  import dcbi_pkg::*;
  logic clk_sys, nrst, req_valid, req_ready, req_supervisor, segment_direct_store_flag;
  logic done, xlat_req, xlat_is_store, xlat_done, xlat_fault, xlat_coherent;
  logic fill_valid, fill_dirty, bcast_valid, bcast_ack, snoop_valid, coh_mode, fault_mode;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0]            s_axi_bresp, s_axi_rresp;
  logic [3:0]            s_axi_wstrb, lag;
  logic [RES_W-1:0]      done_result;
  logic [ADDR_W-1:0]     req_ea, xlat_ea, xlat_pa, fill_pa, bcast_pa, snoop_pa;
  logic [AXI_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0]     s_axi_wdata, s_axi_rdata;
  int                    n_mismatch, tests_run;

  dcbi_top i_dut (.*);
  dcbi_partner i_far (.*);

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic stuck(input int i);
    if (i >= 200) begin
      n_mismatch++;
      $display("BAD handshake expected answer seen none");
      summarize();
    end
  endtask : stuck

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 200; i++) begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    stuck(i);
    check("bresp", 32'(s_axi_bresp), 32'(er));
    s_axi_bready <= 1'b0;
    @(posedge clk_sys);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int i;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 200; i++) begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    stuck(i);
    check("rdata", s_axi_rdata, ed);
    check("rresp", 32'(s_axi_rresp), 32'(er));
    s_axi_rready <= 1'b0;
    @(posedge clk_sys);
  endtask : axi_rd

  task automatic op(input logic [31:0] ea, input logic sup, ds, coh, flt, input logic [2:0] er);
    int i;
    req_ea <= ea;
    req_supervisor <= sup;
    segment_direct_store_flag <= ds;
    coh_mode <= coh;
    fault_mode <= flt;
    req_valid <= 1'b1;
    for (i = 0; i < 200; i++) begin
      @(posedge clk_sys);
      if (req_ready) break;
    end
    stuck(i);
    req_valid <= 1'b0;
    req_ea <= ~ea;
    for (i = 0; i < 200; i++) begin
      @(posedge clk_sys);
      if (done) break;
    end
    stuck(i);
    check("result", 32'(done_result), 32'(er));
    @(posedge clk_sys);
  endtask : op

  task automatic line_ev(input logic [31:0] pa, input logic dirty, input logic snp);
    fill_pa <= pa;
    snoop_pa <= pa;
    fill_dirty <= dirty;
    fill_valid <= !snp;
    snoop_valid <= snp;
    @(posedge clk_sys);
    fill_valid <= 1'b0;
    snoop_valid <= 1'b0;
    @(posedge clk_sys);
  endtask : line_ev

  initial begin
    {nrst, req_valid, req_supervisor, segment_direct_store_flag, coh_mode, fault_mode} = 6'h0;
    {fill_valid, fill_dirty, snoop_valid, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 6'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {req_ea, fill_pa, snoop_pa, s_axi_wdata, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hf;
    lag = 4'h1;
    n_mismatch = 0;
    tests_run = 0;
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    axi_rd(REG_CTRL, 32'h1, RESP_OKAY);
    axi_rd(REG_STATUS, 32'h0, RESP_OKAY);
    axi_rd(8'h20, 32'h0, RESP_SLVERR);
    axi_wr(8'h20, 32'hffff_ffff, RESP_SLVERR);
    $display("test registers done");
    op(32'h0000_1240, 1'b0, 1'b0, 1'b1, 1'b0, RES_PRIV_FAULT);
    line_ev(32'h0000_1240, 1'b1, 1'b0);
    op(32'h0000_1240, 1'b1, 1'b1, 1'b0, 1'b0, RES_DIRECT_STORE);
    op(32'h0000_124c, 1'b1, 1'b0, 1'b0, 1'b0, RES_LOCAL);
    op(32'h0000_124c, 1'b1, 1'b0, 1'b0, 1'b0, RES_MISS);
    op(32'h0000_1240, 1'b1, 1'b0, 1'b0, 1'b1, RES_XLATE_FAULT);
    $display("test local done");
    line_ev(32'h0000_2260, 1'b1, 1'b0);
    lag <= 4'h6;
    op(32'h0000_2264, 1'b1, 1'b0, 1'b1, 1'b0, RES_BCAST);
    lag <= 4'h0;
    op(32'h0000_2264, 1'b1, 1'b0, 1'b1, 1'b0, RES_BCAST);
    $display("test coherent done");
    line_ev(32'h0000_3380, 1'b0, 1'b0);
    line_ev(32'h0000_3380, 1'b0, 1'b1);
    op(32'h0000_3380, 1'b1, 1'b0, 1'b0, 1'b0, RES_MISS);
    axi_wr(REG_CTRL, 32'h0, RESP_OKAY);
    s_axi_wstrb <= 4'h0;
    axi_wr(REG_CTRL, 32'h1, RESP_OKAY);
    axi_rd(REG_CTRL, 32'h0, RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    line_ev(32'h0000_3380, 1'b0, 1'b0);
    line_ev(32'h0000_3380, 1'b0, 1'b1);
    op(32'h0000_3380, 1'b1, 1'b0, 1'b0, 1'b0, RES_LOCAL);
    $display("test snoop done");
    axi_rd(REG_INV_CNT, 32'h4, RESP_OKAY);
    axi_rd(REG_DISCARD_CNT, 32'h2, RESP_OKAY);
    axi_rd(REG_BCAST_CNT, 32'h2, RESP_OKAY);
    axi_rd(REG_FAULT_CNT, 32'h2, RESP_OKAY);
    axi_rd(REG_STATUS, 32'h10, RESP_OKAY);
    axi_wr(REG_FAULT_CNT, 32'h0, RESP_OKAY);
    axi_rd(REG_FAULT_CNT, 32'h0, RESP_OKAY);
    op(32'h0000_1240, 1'b0, 1'b1, 1'b0, 1'b0, RES_PRIV_FAULT);
    axi_rd(REG_FAULT_CNT, 32'h1, RESP_OKAY);
    $display("test counters done");
    summarize();
  end
endmodule : test_data_cache_block_invalidate
